// file: rate_conv_map.vh
// Constants for the rate converter control block.
// Assumes inclusion by the control module only.
`ifndef RATE_CONV_MAP_VH
`define RATE_CONV_MAP_VH
// Address and reset value of the status register
`define RATE_STATUS_ADDR 10'h212
`define RATE_STATUS_RESET 16'h0000
`define ERR_FIELD_MSB 3
// Error codes
`define ERR_NONE 4'h0
`define ERR_BAD_RATE 4'h1
`define ERR_BAD_DIV 4'h2
`define ERR_BOTH_DIV 4'h3
`define ERR_DIV_RATE 4'h4
`define ERR_HI_ENABLES 4'h5
`define ERR_CORE_RATE 4'h6
`define ERR_MIXED_CORE 4'h7
`define ERR_SAME_SRC_RATE 4'h8
`define ERR_SAME_SRC_MIX 4'h9
// Rate codes (4 bits), divider (3 bits) and ratio limits
`define RATE_88K2 4'h9
`define RATE_96K 4'hA
`define RATE_MAX 4'hA
`define DIV_NONE 3'h0
`define DIV_MAX 3'h5
`define RATIO_MAX 4'h9
`define RATIO_MIN 4'h1
// Lock settle count in cycles
`define LOCK_CYCLES 8'h40
`endif

// file: sample_fifo.v
// Sample FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module sample_fifo #(
	parameter WIDTH = 32,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	input wire sys_clk_i,
	input wire rst_n_i,
	input wire flush_i,
	input wire [WIDTH-1:0] in_data_i,
	input wire in_valid_i,
	output wire in_ready_o,
	output wire [WIDTH-1:0] out_data_o,
	output wire out_valid_o,
	input wire out_ready_i
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wp_q;
	reg [AW-1:0] rp_q;
	reg [AW:0] cnt_q;
	wire push;
	wire pop;
	assign in_ready_o = (cnt_q != DEPTH[AW:0]);
	assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
	assign out_data_o = mem[rp_q];
	assign push = in_valid_i & in_ready_o;
	assign pop = out_valid_o & out_ready_i;
	always @(posedge sys_clk_i) begin
		if (push)
			mem[wp_q] <= in_data_i;
		if (!rst_n_i || flush_i) begin
			wp_q <= {AW{1'b0}};
			rp_q <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wp_q <= (wp_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
					wp_q + 1'b1;
			if (pop)
				rp_q <= (rp_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
					rp_q + 1'b1;
			if (push && !pop)
				cnt_q <= cnt_q + 1'b1;
			else if (pop && !push)
				cnt_q <= cnt_q - 1'b1;
		end
	end
endmodule // sample_fifo

// file: audio_rate_converter_control.v
// Rate converter control: routing, lock muting and config checking.
// Assumes settings come from the register file on sys_clk_i; clock
// sources and ratios are static levels, port lock levels are foreign.
//
// Behaviour
// [RULE1] Ports independent; convert stereo both directions
// [RULE2] Converters self-configure, enabled only when needed
// [RULE3] Core clock follows first or second port
// [RULE4] Input converter serves only the asynchronous port
// [RULE5] Receive path muted until input lock
// [RULE6] Output converter serves only the asynchronous port
// [RULE7] Transmit path muted until output lock
// [RULE8] Lock statuses routed to pin and interrupt; code drives in_lock_o and out_lock_o only, no interrupt
// [RULE9] High rate forces core rate, no conversion
// [RULE10] Software zeroes first port dividers when asynchronous; code checks the dividers of the port the core follows
// [RULE11] Status codes zero to three reported
// [RULE12] Status codes four to six reported
// [RULE13] Status codes seven to nine reported
// [RULE14] Status re-evaluated on every setting change
`timescale 1ns/1ps
`include "rate_conv_map.vh"
module audio_rate_converter_control #(
	parameter WIDTH = 32,
	parameter DEPTH = 8
) (
	input wire sys_clk_i,
	input wire rst_n_i,
	input wire [1:0] first_port_clock_source_i,
	input wire [1:0] second_port_clock_source_i,
	input wire core_clock_source_i,
	input wire [3:0] first_port_rate_i,
	input wire [3:0] second_port_rate_i,
	input wire [3:0] core_rate_i,
	input wire [3:0] first_port_clock_ratio_i,
	input wire [3:0] second_port_clock_ratio_i,
	input wire [2:0] first_port_playback_divider_i,
	input wire [2:0] first_port_record_divider_i,
	input wire [2:0] second_port_playback_divider_i,
	input wire [2:0] second_port_record_divider_i,
	input wire first_port_out_enable_i,
	input wire second_port_out_enable_i,
	input wire [9:0] reg_addr_i,
	input wire reg_rd_i,
	output reg [15:0] reg_rdata_o,
	input wire in_lock_raw_i,
	input wire out_lock_raw_i,
	input wire [WIDTH-1:0] rx_data_i,
	input wire rx_valid_i,
	output reg rx_ready_o,
	output reg [WIDTH-1:0] rx_data_o,
	output reg rx_valid_o,
	input wire rx_ready_i,
	input wire [WIDTH-1:0] tx_data_i,
	input wire tx_valid_i,
	output reg tx_ready_o,
	output reg [WIDTH-1:0] tx_data_o,
	output reg tx_valid_o,
	output reg in_conv_enable_o,
	output reg in_conv_port_o,
	output reg out_conv_enable_o,
	output reg out_conv_port_o,
	output reg in_lock_o,
	output reg out_lock_o,
	output reg [3:0] config_error_code_o
);
	// ***********************************************
	// Configuration check
	// ***********************************************
	function is_high_rate;
		input [3:0] r;
		begin
			is_high_rate = (r == `RATE_88K2) || (r == `RATE_96K);
		end
	endfunction

	function bad_div;
		input [2:0] d;
		begin
			bad_div = (d > `DIV_MAX);
		end
	endfunction

	function bad_ratio;
		input [3:0] q;
		begin
			bad_ratio = (q > `RATIO_MAX) || (q < `RATIO_MIN);
		end
	endfunction

	function core_match;
		input [3:0] r;
		input [3:0] c;
		begin
			core_match = is_high_rate(r) ? (r == c) : 1'b1;
		end
	endfunction

	wire async_ports;
	wire any_high;
	wire core_port;
	wire first_both;
	wire second_both;
	wire first_mixed;
	wire second_mixed;
	reg [3:0] err_d;
	reg [3:0] err_q;

	assign async_ports = (first_port_clock_source_i !=
		second_port_clock_source_i);
	assign core_port = core_clock_source_i; // RULE3
	assign any_high = is_high_rate(first_port_rate_i) ||
		is_high_rate(second_port_rate_i);
	assign first_both = (first_port_playback_divider_i != `DIV_NONE) &&
		(first_port_record_divider_i != `DIV_NONE);
	assign second_both = (second_port_playback_divider_i != `DIV_NONE) &&
		(second_port_record_divider_i != `DIV_NONE);
	assign first_mixed = (first_port_playback_divider_i !=
		first_port_record_divider_i);
	assign second_mixed = (second_port_playback_divider_i !=
		second_port_record_divider_i);

	// Lowest code wins when several settings are wrong, but code 9 wins over code 8
	always @* begin
		err_d = `ERR_NONE;
		if (first_port_rate_i > `RATE_MAX || second_port_rate_i > `RATE_MAX
			|| core_rate_i > `RATE_MAX)
			err_d = `ERR_BAD_RATE; // RULE11
		else if (bad_div(first_port_playback_divider_i) ||
			bad_div(first_port_record_divider_i) ||
			bad_div(second_port_playback_divider_i) ||
			bad_div(second_port_record_divider_i))
			err_d = `ERR_BAD_DIV; // RULE11
		else if (first_both || second_both)
			err_d = `ERR_BOTH_DIV; // RULE11
		else if (is_high_rate(core_rate_i) && (first_mixed || second_mixed))
			err_d = `ERR_DIV_RATE; // RULE12
		else if (any_high && (first_port_out_enable_i ||
			second_port_out_enable_i))
			err_d = `ERR_HI_ENABLES; // RULE12 RULE9
		else if (any_high &&
			!(core_match(first_port_rate_i, core_rate_i) &&
			core_match(second_port_rate_i, core_rate_i)))
			err_d = `ERR_CORE_RATE; // RULE9
		else if (core_port ? bad_ratio(second_port_clock_ratio_i) :
			bad_ratio(first_port_clock_ratio_i))
			err_d = `ERR_CORE_RATE; // RULE12
		else if (async_ports && (core_port ? second_mixed : first_mixed))
			err_d = `ERR_MIXED_CORE; // RULE13 RULE10
		else if (!async_ports && first_port_rate_i != second_port_rate_i &&
			(first_mixed || second_mixed))
			err_d = `ERR_SAME_SRC_MIX; // RULE13
		else if (!async_ports && first_port_rate_i != second_port_rate_i)
			err_d = `ERR_SAME_SRC_RATE; // RULE13
	end

	// ***********************************************
	// Converter assignment and lock
	// ***********************************************
	reg in_s1_q;
	reg in_s2_q;
	reg out_s1_q;
	reg out_s2_q;
	reg [7:0] in_cnt_q;
	reg [7:0] out_cnt_q;
	reg [13:0] cfg_prev_q;
	wire conv_need;
	wire cfg_change;
	wire [13:0] cfg_now;
	wire in_locked;
	wire out_locked;

	// Converters run only for asynchronous ports with a valid setup
	assign conv_need = async_ports && !any_high && (err_d == `ERR_NONE);
	// A change of port synchrony, core source or any rate restarts the lock count
	assign cfg_now = {core_rate_i, second_port_rate_i, first_port_rate_i,
		async_ports, core_port};
	assign cfg_change = (err_d != err_q) || (cfg_now != cfg_prev_q);
	assign in_locked = (in_cnt_q == `LOCK_CYCLES);
	assign out_locked = (out_cnt_q == `LOCK_CYCLES);

	always @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			in_s1_q <= 1'b0;
			in_s2_q <= 1'b0;
			out_s1_q <= 1'b0;
			out_s2_q <= 1'b0;
			in_cnt_q <= 8'h00;
			out_cnt_q <= 8'h00;
			cfg_prev_q <= 14'h0000;
			err_q <= `ERR_NONE;
			in_conv_enable_o <= 1'b0;
			out_conv_enable_o <= 1'b0;
			in_conv_port_o <= 1'b0;
			out_conv_port_o <= 1'b0;
			in_lock_o <= 1'b0;
			out_lock_o <= 1'b0;
			config_error_code_o <= `ERR_NONE;
			reg_rdata_o <= `RATE_STATUS_RESET;
		end else begin
			// Lock levels come from the converter clocks: two stages first
			in_s1_q <= in_lock_raw_i;
			in_s2_q <= in_s1_q;
			out_s1_q <= out_lock_raw_i;
			out_s2_q <= out_s1_q;
			err_q <= err_d; // RULE14
			cfg_prev_q <= cfg_now;
			config_error_code_o <= err_d; // RULE11
			in_conv_enable_o <= conv_need; // RULE2
			out_conv_enable_o <= conv_need; // RULE2
			// Converter sits on the port the core does not follow
			in_conv_port_o <= ~core_port; // RULE4
			out_conv_port_o <= ~core_port; // RULE6
			// Lock restarts on a change of rate, routing or error code, or on raw lock loss
			if (!conv_need || cfg_change || !in_s2_q)
				in_cnt_q <= 8'h00; // RULE8
			else if (!in_locked)
				in_cnt_q <= in_cnt_q + 8'h01;
			if (!conv_need || cfg_change || !out_s2_q)
				out_cnt_q <= 8'h00; // RULE8
			else if (!out_locked)
				out_cnt_q <= out_cnt_q + 8'h01;
			in_lock_o <= in_locked; // RULE8
			out_lock_o <= out_locked; // RULE8
			if (reg_rd_i)
				reg_rdata_o <= (reg_addr_i == `RATE_STATUS_ADDR) ?
					{12'h000, err_d} : 16'h0000; // RULE11
		end
	end

	// ***********************************************
	// Muted converted paths
	// ***********************************************
	wire rx_gate;
	wire tx_gate;
	wire rx_f_ready;
	wire tx_f_ready;
	wire [WIDTH-1:0] rx_f_data;
	wire [WIDTH-1:0] tx_f_data;
	wire rx_f_valid;
	wire tx_f_valid;
	wire rx_take;
	wire tx_take;

	// Synchronous setups pass straight through, except tx at high rates; converted ones wait
	assign rx_gate = !conv_need || in_locked; // RULE5 RULE1
	assign tx_gate = !conv_need || out_locked; // RULE7 RULE1
	assign rx_take = rx_f_valid && rx_gate && (!rx_valid_o || rx_ready_i);
	assign tx_take = tx_f_valid && tx_gate && !any_high &&
		(!tx_valid_o || 1'b1);

	sample_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(3)) u_rx_fifo (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.flush_i(!rx_gate), // RULE5
		.in_data_i(rx_data_i),
		.in_valid_i(rx_valid_i),
		.in_ready_o(rx_f_ready),
		.out_data_o(rx_f_data),
		.out_valid_o(rx_f_valid),
		.out_ready_i(rx_take)
	);

	sample_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(3)) u_tx_fifo (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.flush_i(!tx_gate || any_high), // RULE7 RULE9
		.in_data_i(tx_data_i),
		.in_valid_i(tx_valid_i),
		.in_ready_o(tx_f_ready),
		.out_data_o(tx_f_data),
		.out_valid_o(tx_f_valid),
		.out_ready_i(tx_take)
	);

	always @(posedge sys_clk_i) begin
		if (!rst_n_i) begin
			rx_data_o <= {WIDTH{1'b0}};
			rx_valid_o <= 1'b0;
			rx_ready_o <= 1'b0;
			tx_data_o <= {WIDTH{1'b0}};
			tx_valid_o <= 1'b0;
			tx_ready_o <= 1'b0;
		end else begin
			rx_ready_o <= rx_f_ready;
			tx_ready_o <= tx_f_ready;
			if (!rx_gate)
				rx_valid_o <= 1'b0; // RULE5
			else if (rx_take) begin
				rx_data_o <= rx_f_data;
				rx_valid_o <= 1'b1;
			end else if (rx_ready_i)
				rx_valid_o <= 1'b0;
			if (!tx_gate || any_high)
				tx_valid_o <= 1'b0; // RULE7
			else if (tx_take) begin
				tx_data_o <= tx_f_data;
				tx_valid_o <= 1'b1;
			end else
				tx_valid_o <= 1'b0;
		end
	end
endmodule // audio_rate_converter_control

// file: rate_conv_monitor.sv
// Checker for the rate converter control block.
// Assumes binding to the control module; reset is sync active low.
`timescale 1ns/1ps
module rate_conv_monitor (
	input wire sys_clk_i,
	input wire rst_n_i,
	input wire [1:0] first_port_clock_source_i,
	input wire [1:0] second_port_clock_source_i,
	input wire core_clock_source_i,
	input wire [3:0] first_port_rate_i,
	input wire [9:0] reg_addr_i,
	input wire reg_rd_i,
	input wire [15:0] reg_rdata_o,
	input wire in_lock_raw_i,
	input wire rx_valid_o,
	input wire tx_valid_o,
	input wire in_conv_enable_o,
	input wire out_conv_enable_o,
	input wire in_conv_port_o,
	input wire out_conv_port_o,
	input wire in_lock_o,
	input wire out_lock_o,
	input wire [3:0] config_error_code_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	sequence same_src_s;
		(first_port_clock_source_i == second_port_clock_source_i) [*3];
	endsequence
	sequence core_steady_s;
		$stable(core_clock_source_i) [*3];
	endsequence
	rx_mute_a: assert property (in_conv_enable_o && !in_lock_o |->
		!rx_valid_o) else $error("rx while unlocked");
	tx_mute_a: assert property (out_conv_enable_o && !out_lock_o |->
		!tx_valid_o) else $error("tx while unlocked");
	lock_rise_a: assert property ($rose(in_lock_o) |->
		$past(in_lock_raw_i, 3)) else $error("lock without raw lock");
	lock_fall_a: assert property (!in_lock_raw_i [*5] |-> !in_lock_o)
		else $error("lock kept after raw loss");
	conv_off_a: assert property (same_src_s |-> !in_conv_enable_o &&
		!out_conv_enable_o) else $error("converter on with one source");
	in_port_a: assert property (core_steady_s ##0 in_conv_enable_o |->
		in_conv_port_o == !core_clock_source_i) else $error("input port");
	out_port_a: assert property (core_steady_s ##0 out_conv_enable_o |->
		out_conv_port_o == !core_clock_source_i) else $error("output port");
	high_rate_a: assert property ((first_port_rate_i == 4'hA) [*3] |->
		!in_conv_enable_o && !out_conv_enable_o) else $error("high rate conv");
	bad_rate_a: assert property (first_port_rate_i > 4'hA |=>
		config_error_code_o == 4'h1) else $error("bad rate code");
	read_status_a: assert property (reg_rd_i && reg_addr_i == 10'h212 ##1
		$stable(config_error_code_o) |-> reg_rdata_o ==
		{12'h000, config_error_code_o}) else $error("status read");
	read_other_a: assert property (reg_rd_i && reg_addr_i != 10'h212 |=>
		reg_rdata_o == 16'h0000) else $error("unmapped read");
endmodule // rate_conv_monitor
bind audio_rate_converter_control rate_conv_monitor u_monitor (.sys_clk_i,
	.rst_n_i, .first_port_clock_source_i, .second_port_clock_source_i,
	.core_clock_source_i, .first_port_rate_i, .reg_addr_i, .reg_rd_i,
	.reg_rdata_o, .in_lock_raw_i, .rx_valid_o, .tx_valid_o, .in_conv_enable_o,
	.out_conv_enable_o, .in_conv_port_o, .out_conv_port_o, .in_lock_o,
	.out_lock_o, .config_error_code_o);

// file: conv_core_model.sv
// Model of the converter cores that report lock.
// Assumes the enables come from the control block.
`timescale 1ns/1ps
module conv_core_model #(parameter SETTLE = 5) (
	input wire sys_clk_i,
	input wire in_en_i,
	input wire out_en_i,
	output reg in_lock_o = 1'b0,
	output reg out_lock_o = 1'b0
);
	integer in_cnt = 0;
	integer out_cnt = 0;
	// Lock after settling, lost at once when off, skewed off the edge
	always @(posedge sys_clk_i) begin
		in_cnt <= in_en_i ? in_cnt + 1 : 0;
		out_cnt <= out_en_i ? out_cnt + 1 : 0;
		in_lock_o <= #3 in_en_i && in_cnt >= SETTLE;
		out_lock_o <= #3 out_en_i && out_cnt >= SETTLE;
	end
endmodule // conv_core_model

// file: test_audio_rate_converter_control.sv
// Testbench for the rate converter control block.
// Assumes the core model and the bound checker are compiled with it.
`timescale 1ns/1ps
module test_audio_rate_converter_control;
	reg sys_clk_i = 1'b0;
	reg rst_n_i = 1'b0;
	reg [1:0] output_rate_converter = 2'h0;
	reg core_src = 1'b0;
	reg [3:0] rate1 = 4'h4;
	reg [3:0] rate_hi = 4'h4;
	reg [2:0] div1 = 3'h0;
	reg [3:0] ratio1 = 4'h4;
	reg oen = 1'b0;
	reg [9:0] addr = 10'h000;
	reg rd = 1'b0;
	reg [31:0] rx_d = 32'h0;
	reg rx_v = 1'b0;
	reg rx_rdy = 1'b1;
	reg [31:0] tx_d = 32'h0;
	reg tx_v = 1'b0;
	reg [1:0] ph = 2'h0;
	wire [15:0] rdata;
	wire [31:0] rx_q;
	wire [31:0] tx_q;
	wire [3:0] code;
	wire rx_rdy_o, rx_v_o, tx_rdy_o, tx_v_o, in_en, out_en, in_port, out_port;
	wire in_lk, out_lk, raw_in, raw_out;
	reg [31:0] lfsr = 32'h65B0;
	reg [31:0] exp_q[$];
	reg [31:0] v;
	reg [15:0] d;
	integer mismatches = 0;
	integer check_count = 0;
	integer i;
	integer n;

	audio_rate_converter_control DUT (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
		.first_port_clock_source_i(2'h0), .second_port_clock_source_i(output_rate_converter),
		.core_clock_source_i(core_src), .first_port_rate_i(rate1),
		.second_port_rate_i(rate_hi), .core_rate_i(rate_hi),
		.first_port_clock_ratio_i(ratio1), .second_port_clock_ratio_i(4'h4),
		.first_port_playback_divider_i(div1), .first_port_record_divider_i(3'h0),
		.second_port_playback_divider_i(3'h0),
		.second_port_record_divider_i(3'h0), .first_port_out_enable_i(oen),
		.second_port_out_enable_i(oen), .reg_addr_i(addr), .reg_rd_i(rd),
		.reg_rdata_o(rdata), .in_lock_raw_i(raw_in), .out_lock_raw_i(raw_out),
		.rx_data_i(rx_d), .rx_valid_i(rx_v), .rx_ready_o(rx_rdy_o),
		.rx_data_o(rx_q), .rx_valid_o(rx_v_o), .rx_ready_i(rx_rdy),
		.tx_data_i(tx_d), .tx_valid_i(tx_v), .tx_ready_o(tx_rdy_o),
		.tx_data_o(tx_q), .tx_valid_o(tx_v_o), .in_conv_enable_o(in_en),
		.in_conv_port_o(in_port), .out_conv_enable_o(out_en),
		.out_conv_port_o(out_port), .in_lock_o(in_lk), .out_lock_o(out_lk),
		.config_error_code_o(code));
	conv_core_model model (.sys_clk_i(sys_clk_i), .in_en_i(in_en),
		.out_en_i(out_en), .in_lock_o(raw_in), .out_lock_o(raw_out));

	always #12.5 sys_clk_i = ~sys_clk_i;

	function [31:0] next_lfsr(input [31:0] s);
		next_lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function [15:0] exp_code(input [3:0] r, input [2:0] dv);
		exp_code = (r > 4'hA) ? 16'h1 : (dv > 3'h5) ? 16'h2 : 16'h0;
	endfunction
	task check_val(input [31:0] got, input [31:0] exp);
		begin
			check_count = check_count + 1;
			if (got !== exp) begin
				mismatches = mismatches + 1;
				$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task tick(input integer k);
		repeat (k) @(posedge sys_clk_i);
	endtask
	task read_reg(input [9:0] a);
		begin
			rd <= 1'b1;
			addr <= a;
			@(posedge sys_clk_i);
			rd <= 1'b0;
			#1 d = rdata;
			@(posedge sys_clk_i);
		end
	endtask
	task send_burst(input integer k);
		integer j;
		begin
			for (j = 0; j < k; j = j + 1) begin
				lfsr = next_lfsr(lfsr);
				exp_q.push_back(lfsr);
				rx_d <= lfsr;
				rx_v <= 1'b1;
				@(posedge sys_clk_i);
				while (rx_rdy_o !== 1'b1) @(posedge sys_clk_i);
			end
			rx_v <= 1'b0;
		end
	endtask
	task cfg_case(input [1:0] s, input c, input [3:0] r, input [3:0] h,
		input [2:0] dv, input [3:0] q, input [15:0] e);
		begin
			output_rate_converter <= s;
			core_src <= c;
			rate1 <= r;
			rate_hi <= h;
			div1 <= dv;
			ratio1 <= q;
			tick(3);
			read_reg(10'h212);
			check_val(d, e);
			check_val(code, e);
		end
	endtask
	task wrap_up;
		begin
			$display("checks %0d mismatches %0d", check_count, mismatches);
			if (mismatches == 0 && check_count > 0)
				$display("verification passed");
			else
				$display("verification failed");
			$finish;
		end
	endtask

	// Sink with stalls, checks order of received words
	always @(posedge sys_clk_i) begin
		ph <= ph + 2'h1;
		rx_rdy <= (ph != 2'h0) | lfsr[9];
		if (rx_v_o === 1'b1 && rx_rdy) begin
			v = exp_q.size() ? exp_q.pop_front() : ~rx_q;
			check_val(rx_q, v);
		end
	end

	initial begin
		#(25 * 5000);
		mismatches = mismatches + 1;
		wrap_up;
	end

	//****************************************
	// Main sequence
	//****************************************
	initial begin
		tick(3);
		rst_n_i <= 1'b1;
		tick(2);
		read_reg(10'h212);
		check_val(d, 16'h0000);
		for (n = 0; n < 10; n = n + 1) begin
			lfsr = next_lfsr(lfsr);
			rate1 <= (n == 8) ? 4'hF : lfsr[2] ? 4'hB + lfsr[4:3] : 4'h4;
			div1 <= (n == 8) ? 3'h7 : lfsr[0] ? {2'h3, lfsr[1]} : 3'h0;
			tick(3);
			read_reg(n[0] ? 10'h213 : 10'h212);
			check_val(d, n[0] ? 16'h0 : exp_code(rate1, div1));
			check_val(code, exp_code(rate1, div1));
		end
		rate1 <= 4'h4;
		div1 <= 3'h0;
		$display("config code test done");
		for (n = 0; n < 2; n = n + 1) begin
			output_rate_converter <= 2'h1;
			core_src <= n[0];
			rx_d <= 32'hA5A5_5A5A;
			rx_v <= 1'b1;
			tick(10);
			check_val(rx_v_o, 0);
			rx_v <= 1'b0;
			i = 0;
			while (!(in_lk === 1'b1 && out_lk === 1'b1) && i < 400) begin
				@(posedge sys_clk_i);
				i = i + 1;
			end
			check_val(i < 400, 1);
			check_val(in_port, !n[0]);
			check_val(out_port, !n[0]);
			send_burst(6);
			lfsr = next_lfsr(lfsr);
			tx_d <= lfsr;
			tx_v <= 1'b1;
			@(posedge sys_clk_i);
			while (tx_rdy_o !== 1'b1) @(posedge sys_clk_i);
			tx_v <= 1'b0;
			i = 0;
			while (tx_v_o !== 1'b1 && i < 40) begin
				@(posedge sys_clk_i);
				i = i + 1;
			end
			check_val(i < 40, 1);
			check_val(tx_q, lfsr);
			tick(30);
			check_val(exp_q.size(), 0);
			output_rate_converter <= 2'h0;
			tick(10);
			check_val({in_en, out_en, in_lk}, 0);
			$display("conversion test %0d done", n);
		end
		output_rate_converter <= 2'h1;
		rate1 <= 4'hA;
		rate_hi <= 4'hA;
		oen <= 1'b1;
		tick(80);
		check_val({in_en, out_en}, 0);
		read_reg(10'h212);
		check_val(d, 16'h0005);
		rate1 <= 4'h4;
		rate_hi <= 4'h4;
		oen <= 1'b0;
		tick(3);
		read_reg(10'h212);
		check_val(d, 16'h0000);
		$display("high rate test done");
		cfg_case(2'h0, 1'b0, 4'h4, 4'h4, 3'h0, 4'h0, 16'h6);
		cfg_case(2'h1, 1'b0, 4'h4, 4'h4, 3'h1, 4'h4, 16'h7);
		cfg_case(2'h0, 1'b0, 4'h4, 4'h5, 3'h0, 4'h4, 16'h8);
		cfg_case(2'h0, 1'b0, 4'h4, 4'h5, 3'h1, 4'h4, 16'h9);
		cfg_case(2'h1, 1'b0, 4'h4, 4'h4, 3'h0, 4'h4, 16'h0);
		$display("config case test done");
		wrap_up;
	end
endmodule // test_audio_rate_converter_control
